//--- pkg/pmsw_defs.vh
// Operation
// - Bit 15 is high while load holds motor at torque limit, else low.
// - Bit 13 sets when position deviation exceeds following-error window.
// - Bit 13 clears only when deviation or overload alarm is cleared.
// - Accepted new-set-point request (control bit 4) sets bit 12.
// - Host lowers request after acknowledge; device then clears bit 12.
// - Bit 11 is high while any sensor, block, soft or mechanical limit acts.
// - Halt low: bit 10 sets after proper completion within position window.
// - Halt low: interrupted move keeps bit 10 at zero.
// - New operation started after completion clears bit 10.
// - Halt high: bit 10 low while decelerating, high at zero speed.
// - Bit 9 goes high once initialization has completed.
// - Bit 7 high while information exists, clears when causes vanish.
`ifndef PMSW_DEFS_VH
`define PMSW_DEFS_VH

// ----------------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------------
`define PMSW_SW_TORQUE     15
`define PMSW_SW_RSVD14     14
`define PMSW_SW_FOLLOW     13
`define PMSW_SW_ACK        12
`define PMSW_SW_LIMIT      11
`define PMSW_SW_TARGET     10
`define PMSW_SW_REMOTE     9
`define PMSW_SW_RSVD8      8
`define PMSW_SW_WARN       7
`define PMSW_SW_DSM_HI     6
`define PMSW_SW_DSM_LO     0

// ----------------------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------------------
`define PMSW_CW_NEW_SP     4
`define PMSW_CW_HALT       8

// ----------------------------------------------------------------------------
// Alarm codes that clear the following error
// ----------------------------------------------------------------------------
`define PMSW_ALM_DEVIATION 8'h10
`define PMSW_ALM_OVERLOAD  8'h30

// ----------------------------------------------------------------------------
// Register map, byte addresses
// ----------------------------------------------------------------------------
`define PMSW_REG_STATUS    8'h00
`define PMSW_REG_FE_WIN    8'h04
`define PMSW_REG_POS_WIN   8'h08
`define PMSW_REG_IRQ_STAT  8'h0C
`define PMSW_REG_IRQ_MASK  8'h10
`define PMSW_REG_HALT_GAP  8'h14

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PMSW_RST_FE_WIN    32'h0000_1000
`define PMSW_RST_POS_WIN   32'h0000_0010
`define PMSW_RST_MASK      5'h00
`define PMSW_RST_HALT_GAP  16'h0000

// ----------------------------------------------------------------------------
// Interrupt event bits
// ----------------------------------------------------------------------------
`define PMSW_IRQ_W         5
`define PMSW_IRQ_TORQUE    0
`define PMSW_IRQ_FOLLOW    1
`define PMSW_IRQ_ACK       2
`define PMSW_IRQ_LIMIT     3
`define PMSW_IRQ_TARGET    4

`endif

//--- hw/pmsw_sync.v
`timescale 1ns/1ps
module pmsw_sync #(
  parameter W = 1
) (
  input  wire         i_clk_sys,
  input  wire         i_rst_n,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;

  // ----------------------------------------------------------------------------
  // Two-flop synchroniser
  // ----------------------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      stage1 <= {W{1'b0}};
      stage2 <= {W{1'b0}};
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
    end
  end

  assign o_sync = stage2;

endmodule // pmsw_sync

//--- hw/pmsw_top.v
`timescale 1ns/1ps
`include "pmsw_defs.vh"
module pmsw_top (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  // Register port
  input  wire [7:0]  i_reg_addr,
  input  wire [31:0] i_reg_wdata,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  output reg  [31:0] o_reg_rdata,
  output wire        o_irq,
  // Control word from fieldbus side
  input  wire [15:0] i_ctrl_word,
  // Drive conditions
  input  wire        i_torque_limit_hit,
  input  wire [31:0] i_pos_deviation,
  input  wire        i_alarm_clear,
  input  wire [7:0]  i_alarm_code,
  input  wire        i_stop_in,
  input  wire        i_op_enabled,
  input  wire        i_excited,
  input  wire        i_fwd_limit_sensor,
  input  wire        i_rev_limit_sensor,
  input  wire        i_fwd_motion_block,
  input  wire        i_rev_motion_block,
  input  wire        i_soft_limit,
  input  wire        i_mech_limit,
  input  wire        i_move_done,
  input  wire        i_move_abort,
  input  wire [31:0] i_cmd_pos,
  input  wire [31:0] i_fb_pos,
  input  wire [31:0] i_cmd_speed,
  input  wire        i_init_done,
  input  wire [7:0]  i_info_causes,
  input  wire [6:0]  i_dsm_flags,
  // Status outputs
  output reg  [15:0] o_status_word,
  output reg         o_start
);

  // ----------------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------------
  function [31:0] abs32;
    input [31:0] v;
    begin
      abs32 = v[31] ? (~v + 32'h0000_0001) : v;
    end
  endfunction

  function rise;
    input now;
    input was;
    begin
      rise = now & ~was;
    end
  endfunction

  function wr_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] reg_addr;
    begin
      wr_hit = wr & (addr == reg_addr);
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Set-point handshake states
  // ----------------------------------------------------------------------------
  localparam [1:0] SP_IDLE = 2'h0;
  localparam [1:0] SP_ACK  = 2'h1;
  localparam [1:0] SP_HOLD = 2'h2;

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  wire [3:0]              pins_sync;
  reg  [31:0]             fe_window;
  reg  [31:0]             pos_window;
  reg  [`PMSW_IRQ_W-1:0]  irq_status;
  reg  [`PMSW_IRQ_W-1:0]  irq_mask;
  reg  [15:0]             halt_gap;
  reg  [15:0]             gap_count;
  reg  [15:0]             next_gap_count;
  reg                     follow_err;
  reg                     next_follow_err;
  reg  [1:0]              sp_state;
  reg  [1:0]              next_sp_state;
  reg                     next_ack;
  reg                     move_ok;
  reg                     next_move_ok;
  reg                     next_target;
  reg                     new_sp_q;
  reg  [15:0]             status_q;
  reg  [15:0]             next_status;
  reg  [`PMSW_IRQ_W-1:0]  events;
  reg  [31:0]             rd_mux;
  wire                    new_sp;
  wire                    halt;
  wire                    limit_any;
  wire                    start_ok;
  wire                    start_req;
  wire                    dev_over;
  wire                    fe_clear;
  wire                    in_window;
  wire                    speed_zero;

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  pmsw_sync #(
    .W (4)
  ) u_pin_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_rev_motion_block, i_fwd_motion_block,
                 i_rev_limit_sensor, i_fwd_limit_sensor}),
    .o_sync    (pins_sync)
  );

  // ----------------------------------------------------------------------------
  // Condition decode
  // ----------------------------------------------------------------------------
  assign new_sp     = i_ctrl_word[`PMSW_CW_NEW_SP];
  assign halt       = i_ctrl_word[`PMSW_CW_HALT];
  assign limit_any  = (|pins_sync) | i_soft_limit | i_mech_limit;
  assign dev_over   = abs32(i_pos_deviation) > fe_window;
  assign fe_clear   = i_alarm_clear &
                      ((i_alarm_code == `PMSW_ALM_DEVIATION) |
                       (i_alarm_code == `PMSW_ALM_OVERLOAD));
  assign in_window  = abs32(i_fb_pos - i_cmd_pos) <= pos_window;
  assign speed_zero = (i_cmd_speed == 32'h0000_0000);
  // Start refused while halted, stopped, not enabled, unexcited or too soon
  assign start_ok   = ~halt & ~i_stop_in & i_op_enabled & i_excited &
                      (gap_count == 16'h0000);
  assign start_req  = rise(new_sp, new_sp_q) & start_ok;

  // ----------------------------------------------------------------------------
  // Halt release guard
  // ----------------------------------------------------------------------------
  always @* begin
    next_gap_count = gap_count;
    if (halt) begin
      next_gap_count = halt_gap;
    end else if (gap_count != 16'h0000) begin
      next_gap_count = gap_count - 16'h0001;
    end
  end

  // ----------------------------------------------------------------------------
  // Following error
  // ----------------------------------------------------------------------------
  always @* begin
    next_follow_err = follow_err;
    if (dev_over) begin
      next_follow_err = 1'b1;
    end else if (fe_clear) begin
      next_follow_err = 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Set-point acknowledge
  // ----------------------------------------------------------------------------
  always @* begin
    next_sp_state = sp_state;
    case (sp_state)
      SP_IDLE: begin
        if (start_req) begin
          next_sp_state = SP_ACK;
        end else if (rise(new_sp, new_sp_q)) begin
          next_sp_state = SP_HOLD;
        end
      end
      SP_ACK: begin
        if (!new_sp) begin
          next_sp_state = SP_IDLE;
        end
      end
      SP_HOLD: begin
        // Refused request waits for bit 4 to drop
        if (!new_sp) begin
          next_sp_state = SP_IDLE;
        end
      end
      default: begin
        next_sp_state = SP_IDLE;
      end
    endcase
    next_ack = (next_sp_state == SP_ACK);
  end

  // ----------------------------------------------------------------------------
  // Target reached
  // ----------------------------------------------------------------------------
  always @* begin
    next_move_ok = move_ok;
    if (start_req || i_move_abort) begin
      next_move_ok = 1'b0;
    end else if (i_move_done) begin
      next_move_ok = 1'b1;
    end
  end

  always @* begin
    next_target = 1'b0;
    if (start_req) begin
      next_target = 1'b0;
    end else if (halt) begin
      next_target = speed_zero;
    end else begin
      next_target = next_move_ok & in_window;
    end
  end

  // ----------------------------------------------------------------------------
  // Status word assembly
  // ----------------------------------------------------------------------------
  always @* begin
    next_status                          = 16'h0000;
    next_status[`PMSW_SW_TORQUE]         = i_torque_limit_hit;
    next_status[`PMSW_SW_RSVD14]         = 1'b0;
    next_status[`PMSW_SW_FOLLOW]         = next_follow_err;
    next_status[`PMSW_SW_ACK]            = next_ack;
    next_status[`PMSW_SW_LIMIT]          = limit_any;
    next_status[`PMSW_SW_TARGET]         = next_target;
    next_status[`PMSW_SW_REMOTE]         = i_init_done;
    next_status[`PMSW_SW_RSVD8]          = 1'b0;
    next_status[`PMSW_SW_WARN]           = |i_info_causes;
    next_status[`PMSW_SW_DSM_HI:`PMSW_SW_DSM_LO] = i_dsm_flags;
  end

  // ----------------------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------------------
  always @* begin
    events                   = {`PMSW_IRQ_W{1'b0}};
    events[`PMSW_IRQ_TORQUE] = rise(next_status[`PMSW_SW_TORQUE],
                                    status_q[`PMSW_SW_TORQUE]);
    events[`PMSW_IRQ_FOLLOW] = rise(next_status[`PMSW_SW_FOLLOW],
                                    status_q[`PMSW_SW_FOLLOW]);
    events[`PMSW_IRQ_ACK]    = rise(next_status[`PMSW_SW_ACK],
                                    status_q[`PMSW_SW_ACK]);
    events[`PMSW_IRQ_LIMIT]  = rise(next_status[`PMSW_SW_LIMIT],
                                    status_q[`PMSW_SW_LIMIT]);
    events[`PMSW_IRQ_TARGET] = rise(next_status[`PMSW_SW_TARGET],
                                    status_q[`PMSW_SW_TARGET]);
  end

  assign o_irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------------------
  // Status state registers
  // ----------------------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      gap_count     <= 16'h0000;
      follow_err    <= 1'b0;
      sp_state      <= SP_IDLE;
      move_ok       <= 1'b0;
      new_sp_q      <= 1'b0;
      status_q      <= 16'h0000;
      o_status_word <= 16'h0000;
      o_start       <= 1'b0;
    end else begin
      gap_count     <= next_gap_count;
      follow_err    <= next_follow_err;
      sp_state      <= next_sp_state;
      move_ok       <= next_move_ok;
      new_sp_q      <= new_sp;
      status_q      <= next_status;
      o_status_word <= next_status;
      o_start       <= start_req;
    end
  end

  // ----------------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      fe_window <= `PMSW_RST_FE_WIN;
    end else if (wr_hit(i_reg_wr, i_reg_addr, `PMSW_REG_FE_WIN)) begin
      fe_window <= i_reg_wdata;
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pos_window <= `PMSW_RST_POS_WIN;
    end else if (wr_hit(i_reg_wr, i_reg_addr, `PMSW_REG_POS_WIN)) begin
      pos_window <= i_reg_wdata;
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      irq_mask <= `PMSW_RST_MASK;
    end else if (wr_hit(i_reg_wr, i_reg_addr, `PMSW_REG_IRQ_MASK)) begin
      irq_mask <= i_reg_wdata[`PMSW_IRQ_W-1:0];
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      halt_gap <= `PMSW_RST_HALT_GAP;
    end else if (wr_hit(i_reg_wr, i_reg_addr, `PMSW_REG_HALT_GAP)) begin
      halt_gap <= i_reg_wdata[15:0];
    end
  end

  // ----------------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------------
  // New events win over a write-one clear
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      irq_status <= {`PMSW_IRQ_W{1'b0}};
    end else if (wr_hit(i_reg_wr, i_reg_addr, `PMSW_REG_IRQ_STAT)) begin
      irq_status <= (irq_status & ~i_reg_wdata[`PMSW_IRQ_W-1:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  // ----------------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------------
  always @* begin
    case (i_reg_addr)
      `PMSW_REG_STATUS:   rd_mux = {16'h0000, status_q};
      `PMSW_REG_FE_WIN:   rd_mux = fe_window;
      `PMSW_REG_POS_WIN:  rd_mux = pos_window;
      `PMSW_REG_IRQ_STAT: rd_mux = {{(32-`PMSW_IRQ_W){1'b0}}, irq_status};
      `PMSW_REG_IRQ_MASK: rd_mux = {{(32-`PMSW_IRQ_W){1'b0}}, irq_mask};
      `PMSW_REG_HALT_GAP: rd_mux = {16'h0000, halt_gap};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_mux;
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // pmsw_top

//--- tb/pmsw_top_asserts.sv
`timescale 1ns/1ps
module pmsw_top_asserts (
  input wire        i_clk_sys,
  input wire        i_rst_n,
  input wire [15:0] i_ctrl_word,
  input wire        i_torque_limit_hit,
  input wire        i_alarm_clear,
  input wire [7:0]  i_alarm_code,
  input wire        i_soft_limit,
  input wire        i_mech_limit,
  input wire [31:0] i_cmd_speed,
  input wire        i_init_done,
  input wire [7:0]  i_info_causes,
  input wire [6:0]  i_dsm_flags,
  input wire [15:0] o_status_word,
  input wire        o_start
);
  // One cycle of history since reset release
  reg up;
  always @(posedge i_clk_sys) up <= i_rst_n;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  property p_torque; up |-> o_status_word[15] == $past(i_torque_limit_hit); endproperty
  a_torque: assert property (p_torque) else $error("torque bit wrong");
  property p_follow; o_status_word[13] && !(i_alarm_clear && (i_alarm_code == 8'h10 ||
    i_alarm_code == 8'h30)) |=> o_status_word[13]; endproperty
  a_follow: assert property (p_follow) else $error("follow bit dropped");
  property p_start; o_start |-> o_status_word[12] && !o_status_word[10]; endproperty
  a_start: assert property (p_start) else $error("start without ack");
  property p_gate; o_start |-> $past(i_ctrl_word[4]) && !$past(i_ctrl_word[8]); endproperty
  a_gate: assert property (p_gate) else $error("start not requested");
  property p_ackclr; up && !$past(i_ctrl_word[4]) |-> !o_status_word[12]; endproperty
  a_ackclr: assert property (p_ackclr) else $error("ack held");
  property p_halt; up && $past(i_ctrl_word[8]) |->
    o_status_word[10] == ($past(i_cmd_speed) == 32'h0000_0000); endproperty
  a_halt: assert property (p_halt) else $error("halt target wrong");
  property p_limit; up && $past(i_soft_limit || i_mech_limit) |-> o_status_word[11]; endproperty
  a_limit: assert property (p_limit) else $error("limit bit low");
  property p_remote; up |-> o_status_word[9] == $past(i_init_done); endproperty
  a_remote: assert property (p_remote) else $error("remote bit wrong");
  property p_warn; up |-> o_status_word[7] == |$past(i_info_causes); endproperty
  a_warn: assert property (p_warn) else $error("warning bit wrong");
  property p_fixed; up |-> !o_status_word[14] && !o_status_word[8] &&
    o_status_word[6:0] == $past(i_dsm_flags); endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bits wrong");
  c_start: cover property (o_start);
  c_follow: cover property ($rose(o_status_word[13]));
  c_target: cover property (o_status_word[10] && !i_ctrl_word[8]);
endmodule // pmsw_top_asserts
bind pmsw_top pmsw_top_asserts u_chk (.*);

//--- tb/pmsw_host_model.sv
`timescale 1ns/1ps
module pmsw_host_model (
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  input  wire        i_go,
  input  wire        i_halt,
  input  wire [15:0] i_status_word,
  output reg  [15:0] o_ctrl_word,
  output reg         o_acked,
  output reg         o_refused,
  output reg         o_push_done
);
  reg [3:0] wait_cnt;
  reg [1:0] gap;
  reg       tq_d;
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      {o_ctrl_word, o_acked, o_refused, o_push_done, wait_cnt, gap, tq_d} <= 26'h000_0000;
    end else begin
      o_ctrl_word[8] <= i_halt;
      tq_d <= i_status_word[15];
      o_push_done <= i_status_word[15] & ~tq_d;
      if (i_halt)
        gap <= 2'h3;
      else if (gap != 2'h0)
        gap <= gap - 2'h1;
      if (i_go && !o_ctrl_word[4] && gap == 2'h0) begin
        o_ctrl_word[4] <= 1'b1;
        {wait_cnt, o_acked, o_refused} <= 0;
      end else if (o_ctrl_word[4]) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (i_status_word[12]) begin
          o_ctrl_word[4] <= 1'b0;
          o_acked <= 1'b1;
        end else if (wait_cnt == 4'h8) begin
          o_ctrl_word[4] <= 1'b0;
          o_refused <= 1'b1;
        end
      end
    end
  end
endmodule // pmsw_host_model

//--- tb/pmsw_top_tb.sv
`timescale 1ns/1ps
`include "pmsw_defs.vh"
module pmsw_top_tb;
  localparam [15:0] B = 16'h0227;
  reg         i_clk_sys, i_rst_n, i_reg_wr, i_reg_rd, i_torque_limit_hit, i_alarm_clear;
  reg         i_stop_in, i_op_enabled, i_excited, i_move_done, i_move_abort, i_init_done;
  reg         go, halt;
  reg  [7:0]  i_reg_addr, i_alarm_code, i_info_causes;
  reg  [31:0] i_reg_wdata, i_pos_deviation, i_cmd_pos, i_fb_pos, i_cmd_speed;
  reg  [6:0]  i_dsm_flags;
  reg  [5:0]  lim;
  wire [31:0] o_reg_rdata;
  wire [15:0] o_status_word, i_ctrl_word;
  wire        o_irq, o_start, acked, refused, push_done, i_soft_limit, i_mech_limit;
  wire        i_fwd_limit_sensor, i_rev_limit_sensor, i_fwd_motion_block, i_rev_motion_block;
  integer     num_errors = 0, n_compared = 0, cyc = 0, n_push = 0, k, w;
  assign {i_mech_limit, i_soft_limit, i_rev_motion_block, i_fwd_motion_block,
          i_rev_limit_sensor, i_fwd_limit_sensor} = lim;
  pmsw_top DUT (.*);
  pmsw_host_model u_host (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_go(go), .i_halt(halt),
    .i_status_word(o_status_word), .o_ctrl_word(i_ctrl_word), .o_acked(acked),
    .o_refused(refused), .o_push_done(push_done));
  always @(posedge i_clk_sys) n_push <= n_push + push_done;
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors = num_errors + 1;
      wrap_up;
    end
  end
  // ---------------------------------
  // Access and compare tasks
  // ---------------------------------
  task wrap_up; begin
    $display("errors %0d, compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end endtask
  task cmp(input [31:0] got, input [31:0] exp); begin
    n_compared = n_compared + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  end endtask
  task reg_wr(input [7:0] a, input [31:0] d); begin
    @(posedge i_clk_sys) {i_reg_addr, i_reg_wdata, i_reg_wr} <= {a, d, 1'b1};
    @(posedge i_clk_sys) i_reg_wr <= 1'b0;
  end endtask
  task reg_rd(input [7:0] a, input [31:0] e); begin
    @(posedge i_clk_sys) {i_reg_addr, i_reg_rd} <= {a, 1'b1};
    @(posedge i_clk_sys) i_reg_rd <= 1'b0;
    #1 cmp(o_reg_rdata, e);
  end endtask
  task chks(input [15:0] e); begin
    repeat (4) @(posedge i_clk_sys);
    #1 cmp({16'h0000, o_status_word}, {16'h0000, e});
  end endtask
  task sp(input exp); begin
    @(posedge i_clk_sys) go <= 1'b1;
    w = 0;
    while (!i_ctrl_word[4] && w < 20) begin
      @(posedge i_clk_sys);
      w = w + 1;
    end
    go <= 1'b0;
    w = 0;
    while (!(acked | refused) && w < 20) begin
      @(posedge i_clk_sys);
      w = w + 1;
    end
    #1 cmp({30'h0000_0000, refused, acked}, {30'h0000_0000, ~exp, exp});
  end endtask
  task mv(input [1:0] p); begin
    @(posedge i_clk_sys) {i_move_done, i_move_abort} <= p;
    @(posedge i_clk_sys) {i_move_done, i_move_abort} <= 2'b00;
  end endtask
  task alm(input [7:0] c); begin
    @(posedge i_clk_sys) {i_alarm_clear, i_alarm_code} <= {1'b1, c};
    @(posedge i_clk_sys) i_alarm_clear <= 1'b0;
  end endtask
  // ---------------------------------
  // Main sequence
  // ---------------------------------
  initial begin
    {i_reg_wr, i_reg_rd, i_torque_limit_hit, i_alarm_clear, i_stop_in, i_move_done} <= 6'h00;
    {i_move_abort, go, halt, i_reg_addr, i_alarm_code, i_info_causes, lim} <= 33'h0_0000_0000;
    {i_reg_wdata, i_pos_deviation, i_cmd_pos, i_fb_pos, i_cmd_speed} <= 160'h0;
    {i_op_enabled, i_excited, i_init_done, i_rst_n} <= 4'he;
    i_dsm_flags <= 7'h27;
    repeat (5) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    reg_rd(`PMSW_REG_FE_WIN, `PMSW_RST_FE_WIN);
    reg_rd(`PMSW_REG_POS_WIN, `PMSW_RST_POS_WIN);
    reg_rd(`PMSW_REG_HALT_GAP, 32'h0000_0000);
    reg_rd(`PMSW_REG_IRQ_MASK, 32'h0000_0000);
    reg_rd(`PMSW_REG_IRQ_STAT, 32'h0000_0000);
    reg_rd(8'h18, 32'h0000_0000);
    reg_wr(`PMSW_REG_STATUS, 32'h0000_ffff);
    reg_rd(`PMSW_REG_STATUS, {16'h0000, B});
    @(posedge i_clk_sys) i_torque_limit_hit <= 1'b1;
    chks(B | 16'h8000);
    reg_rd(`PMSW_REG_IRQ_STAT, 32'h0000_0001);
    cmp({31'h0000_0000, o_irq}, 32'h0000_0000);
    reg_wr(`PMSW_REG_IRQ_MASK, 32'h0000_0001);
    #1 cmp({31'h0000_0000, o_irq}, 32'h0000_0001);
    reg_wr(`PMSW_REG_IRQ_STAT, 32'h0000_0001);
    #1 cmp({31'h0000_0000, o_irq}, 32'h0000_0000);
    @(posedge i_clk_sys) i_torque_limit_hit <= 1'b0;
    chks(B);
    for (k = 0; k < 6; k = k + 1) begin
      @(posedge i_clk_sys) lim <= 6'h01 << k;
      chks(B | 16'h0800);
      @(posedge i_clk_sys) lim <= 6'h00;
      chks(B);
    end
    @(posedge i_clk_sys) i_pos_deviation <= 32'h0000_1000;
    chks(B);
    @(posedge i_clk_sys) i_pos_deviation <= 32'h0000_1001;
    chks(B | 16'h2000);
    @(posedge i_clk_sys) i_pos_deviation <= 32'h0000_0000;
    alm(8'h20);
    chks(B | 16'h2000);
    alm(`PMSW_ALM_DEVIATION);
    chks(B);
    @(posedge i_clk_sys) i_pos_deviation <= 32'hffff_efff;
    chks(B | 16'h2000);
    @(posedge i_clk_sys) i_pos_deviation <= 32'h0000_0000;
    alm(`PMSW_ALM_OVERLOAD);
    chks(B);
    @(posedge i_clk_sys) i_fb_pos <= 32'h0000_0010;
    sp(1'b1);
    mv(2'b01);
    chks(B);
    @(posedge i_clk_sys) i_fb_pos <= 32'h0000_0011;
    mv(2'b10);
    chks(B);
    @(posedge i_clk_sys) i_fb_pos <= 32'hffff_fff0;
    chks(B | 16'h0400);
    sp(1'b1);
    chks(B);
    for (k = 0; k < 3; k = k + 1) begin
      @(posedge i_clk_sys) {i_stop_in, i_op_enabled, i_excited} <= 3'b011 ^ (3'b100 >> k);
      sp(1'b0);
    end
    @(posedge i_clk_sys) {i_stop_in, i_op_enabled, i_excited} <= 3'b011;
    @(posedge i_clk_sys) {halt, i_cmd_speed} <= {1'b1, 32'h0000_0005};
    chks(B);
    @(posedge i_clk_sys) i_cmd_speed <= 32'h0000_0000;
    chks(B | 16'h0400);
    @(posedge i_clk_sys) halt <= 1'b0;
    sp(1'b1);
    reg_wr(`PMSW_REG_HALT_GAP, 32'h0000_0008);
    reg_rd(`PMSW_REG_HALT_GAP, 32'h0000_0008);
    @(posedge i_clk_sys) halt <= 1'b1;
    @(posedge i_clk_sys) halt <= 1'b0;
    sp(1'b0);
    sp(1'b1);
    @(posedge i_clk_sys) i_info_causes <= 8'h40;
    chks(B | 16'h0080);
    @(posedge i_clk_sys) {i_info_causes, i_init_done, i_dsm_flags} <= {8'h00, 1'b0, 7'h58};
    chks(16'h0058);
    cmp(n_push, 32'h0000_0001);
    wrap_up;
  end
endmodule // pmsw_top_tb
